// file: rdnp_decoder.sv
// Region decoder with nested protection blocks and its register file.
//
// Summary of operation
// RL1 - Each unit-enable line defines its own region.
// RL2 - Origin holds top twenty address bits.
// RL3 - Extent code sets how many lines compared.
// RL4 - Extent zero never asserts the line.
// RL5 - Software aligns origin to block size.
// RL6 - On-chip hit wins, no external cycle.
// RL7 - Boot origin reset follows exception prefix bit.
// RL8 - Fixed pairs: boot/1, 2/3, 4/5.
// RL9 - Nested block protection replaces main block's.
// RL10 - Main block line asserts for nested hits.
// RL11 - Nested flag on 1,3,5 makes nested block.
// RL12 - Software matches nested handshake settings to main.
// RL13 - Mismatched handshake settings are ORed together.
// RL14 - Nested decoder line never acts as enable.
// RL15 - Nested line strobes may serve any region.
// RL16 - Nested flag ignored on boot, 2, 4.
// RL17 - Paired boot nested decoder beats dedicated one.
// RL18 - Dedicated boot nested block governs otherwise.
// RL19 - Dedicated decoder: own origin, flag clears at reset.
// RL20 - Software makes nested blocks smaller than main.
// RL21 - Violation raises error, withholds unit enable.
// RL22 - Privilege, fetch and store violations detected.
// RL23 - Matches evaluated combinationally from address, registers.
`timescale 1ns/1ps
`default_nettype none
module rdnp_decoder
  import rdnp_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [ADDR_W-1:0]     reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [ADDR_W-1:0]     reg_rdata_o,
  input  wire logic                  exception_prefix_bit_i,
  input  wire rdnp_acc_s             acc_i,
  output logic      [NUM_LINES-1:0]  region_select_n_o,
  output logic                       transfer_error_signal_o,
  output rdnp_attr_s                 attr_o
);

  // ==========================================================================
  // Register file state
  // ==========================================================================
  logic [ORIGIN_W-1:0] origin_reg  [NUM_DEC];
  logic [ORIGIN_W-1:0] origin_next [NUM_DEC];
  rdnp_opt_s           option_reg  [NUM_DEC];
  rdnp_opt_s           option_next [NUM_DEC];
  logic [ADDR_W-1:0]   rdata_reg;
  logic [ADDR_W-1:0]   rdata_next;
  rdnp_stat_s          stat_reg;
  rdnp_stat_s          stat_next;

  logic [2:0] bank;
  logic [2:0] idx;

  assign bank = reg_addr_i[BANK_MSB:BANK_LSB];
  assign idx  = reg_addr_i[IDX_MSB:IDX_LSB];

  // ==========================================================================
  // Register writes and reads
  // ==========================================================================
  // Index seven of either bank is unmapped: writes drop, reads give zero.
  always_comb
  begin
    for (int i = 0; i < NUM_DEC; i++)
    begin
      origin_next[i] = origin_reg[i];
      option_next[i] = option_reg[i];
      if (reg_wr_i && (idx == 3'(i)) && (bank == ORIGIN_BANK))
      begin
        origin_next[i] = reg_wdata_i[ADDR_W-1:ORIGIN_LSB];  // see RL2 RL19
      end
      if (reg_wr_i && (idx == 3'(i)) && (bank == OPTION_BANK))
      begin
        option_next[i] = rdnp_opt_s'(reg_wdata_i & OPT_WMASK);
      end
    end
    rdata_next = '0;
    if (reg_rd_i)
    begin
      if (bank == STATUS_BANK && idx == '0)
      begin
        rdata_next = ADDR_W'(stat_reg);
      end
      for (int i = 0; i < NUM_DEC; i++)
      begin
        if (idx == 3'(i) && bank == ORIGIN_BANK)
        begin
          rdata_next = {origin_reg[i], {ORIGIN_LSB{1'b0}}};
        end
        if (idx == 3'(i) && bank == OPTION_BANK)
        begin
          rdata_next = option_reg[i];
        end
      end
    end
  end

  // The boot origin is caught from the prefix bit while reset is held.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NUM_DEC; i++)
      begin
        origin_reg[i] <= ORIGIN_RESET;
        option_reg[i] <= OPT_RESET;  // see RL19
      end
      origin_reg[LINE_BOOT] <= exception_prefix_bit_i ?
                               BOOT_ORIGIN_PREFIX_1 :
                               BOOT_ORIGIN_PREFIX_0;  // see RL7
      option_reg[LINE_BOOT] <= BOOT_OPT_RESET;
      rdata_reg             <= '0;
    end
    else
    begin
      origin_reg <= origin_next;
      option_reg <= option_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ==========================================================================
  // Address comparators, one per decoder
  // ==========================================================================
  logic [NUM_DEC-1:0] hit;

  // Compare is combinational on the live address and registers.
  for (genvar g = 0; g < NUM_DEC; g++)
  begin : g_match
    rdnp_region_match u_match
    (
      .origin_i  (origin_reg[g]),
      .extent_i  (option_reg[g].extent),
      .addr_hi_i (acc_i.addr[ADDR_W-1:ORIGIN_LSB]),
      .hit_o     (hit[g])
    );  // see RL3 RL4 RL23
  end

  // ==========================================================================
  // Role of each line decoder
  // ==========================================================================
  logic [NUM_LINES-1:0] nested_on;
  logic [NUM_LINES-1:0] line_hit;
  logic                 boot_nest_on;

  // Only odd lines can be nested; the flag on even lines is ignored.
  // A nested line keeps its strobe role for any region but is never an
  // enable, so its pin function field plays no part in decoding here.
  always_comb
  begin
    for (int i = 0; i < NUM_LINES; i++)
    begin
      nested_on[i] = (i % 2 == 1) && option_reg[i].nested;  // see RL11 RL16
      line_hit[i]  = hit[i] && !nested_on[i] &&
                     (option_reg[i].pin_function_field == PIN_FUNCTION_FIELD_UNIT_ENABLE);  // see RL1 RL14 RL15
    end
    boot_nest_on = option_reg[DEC_BOOT_NEST].nested;
  end

  // ==========================================================================
  // Selection and effective settings
  // ==========================================================================
  logic       any_hit;
  logic [2:0] sel;
  logic       use_sub;
  rdnp_opt_s  base_opt;
  rdnp_opt_s  sub_opt;
  rdnp_opt_s  eff_opt;
  logic       violation;

  // Overlapping main regions are a software fault; the lowest line wins.
  always_comb
  begin
    any_hit = 1'b0;
    sel     = '0;
    for (int i = NUM_LINES - 1; i >= 0; i--)
    begin
      if (line_hit[i])
      begin
        any_hit = 1'b1;
        sel     = 3'(i);
      end
    end
    base_opt = option_reg[sel];
    sub_opt  = base_opt;
    use_sub  = 1'b0;
    if (!sel[0] && nested_on[3'(sel + 3'h1)] && hit[3'(sel + 3'h1)])
    begin
      use_sub = 1'b1;  // see RL8 RL9 RL17
      sub_opt = option_reg[3'(sel + 3'h1)];
    end
    else if (sel == 3'(LINE_BOOT) && boot_nest_on && hit[DEC_BOOT_NEST])
    begin
      use_sub = 1'b1;  // see RL18
      sub_opt = option_reg[DEC_BOOT_NEST];
    end
    eff_opt = use_sub ? sub_opt : base_opt;  // see RL9
    // Handshake and width settings merge so a mismatch stays safe.
    eff_opt.interface_kind_field = base_opt.interface_kind_field | (use_sub ? sub_opt.interface_kind_field : '0);
    eff_opt.handshake_return_flag = base_opt.handshake_return_flag | (use_sub && sub_opt.handshake_return_flag);
    eff_opt.transfer_latency_field = base_opt.transfer_latency_field | (use_sub ? sub_opt.transfer_latency_field : '0);
    eff_opt.ps    = base_opt.ps | (use_sub ? sub_opt.ps : '0);  // see RL13
  end

  rdnp_prot_check u_prot
  (
    .opt_i       (eff_opt),
    .acc_i       (acc_i),
    .violation_o (violation)
  );  // see RL22

  // ==========================================================================
  // Access answer
  // ==========================================================================
  logic [NUM_LINES-1:0] sel_n_reg;
  logic [NUM_LINES-1:0] sel_n_next;
  logic                 err_reg;
  logic                 err_next;
  rdnp_attr_s           attr_reg;
  rdnp_attr_s           attr_next;
  logic                 ext_access;

  // The decision is registered, so it shows one cycle after the strobe.
  // This keeps every output glitch free at the cost of one cycle.
  always_comb
  begin
    ext_access = acc_i.valid && !acc_i.internal && any_hit;  // see RL6
    sel_n_next = '1;
    err_next   = 1'b0;
    attr_next  = '0;
    stat_next  = stat_reg;
    if (ext_access)
    begin
      err_next = violation;  // see RL21
      if (!violation)
      begin
        sel_n_next[sel] = 1'b0;  // see RL10 RL21
      end
      attr_next.ci    = eff_opt.ci;
      attr_next.handshake_return_flag = eff_opt.handshake_return_flag;
      attr_next.transfer_latency_field = eff_opt.transfer_latency_field;
      attr_next.ps    = eff_opt.ps;
      attr_next.interface_kind_field = eff_opt.interface_kind_field;
      stat_next.hit    = 1'b1;
      stat_next.error  = violation;
      stat_next.nested = use_sub;
      stat_next.line   = sel;
    end
    else if (acc_i.valid)
    begin
      stat_next = '0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sel_n_reg <= '1;
      err_reg   <= 1'b0;
      attr_reg  <= '0;
      stat_reg  <= '0;
    end
    else
    begin
      sel_n_reg <= sel_n_next;
      err_reg   <= err_next;
      attr_reg  <= attr_next;
      stat_reg  <= stat_next;
    end
  end

  assign region_select_n_o       = sel_n_reg;
  assign transfer_error_signal_o = err_reg;
  assign attr_o                  = attr_reg;

endmodule : rdnp_decoder
`default_nettype wire

// file: rdnp_pkg.sv
// Shared constants and types for the region decoder with nested protection.
package rdnp_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_LINES     = 6;   // Boot line plus region lines 1 to 5.
  localparam int NUM_DEC       = 7;   // Line decoders plus boot nested one.
  localparam int DEC_BOOT_NEST = 6;   // Index of the dedicated boot decoder.
  localparam int LINE_BOOT     = 0;
  localparam int ADDR_W        = 32;
  localparam int ORIGIN_W      = 20;
  localparam int ORIGIN_LSB    = 12;  // Lowest address line an origin holds.
  localparam int REG_ADDR_W    = 8;
  localparam int DROP_W        = 5;

  // ==========================================================================
  // Register map: bank in address bits 7:5, decoder index in bits 4:2
  // ==========================================================================
  localparam int BANK_MSB = 7;
  localparam int BANK_LSB = 5;
  localparam int IDX_MSB  = 4;
  localparam int IDX_LSB  = 2;
  localparam logic [2:0] ORIGIN_BANK = 3'h0;  // Origins at 0x00..0x18.
  localparam logic [2:0] OPTION_BANK = 3'h1;  // Options at 0x20..0x38.
  localparam logic [2:0] STATUS_BANK = 3'h2;  // Decode status at 0x40.

  // ==========================================================================
  // Option register layout, most significant field first
  // ==========================================================================
  typedef struct packed {
    logic [3:0] extent;     // region_extent_field
    logic       nested;     // nested_block_flag
    logic       privileged_only_flag;       // privileged_only_flag
    logic       dsp;        // Data only, no instruction fetch.
    logic       wp;         // Read only.
    logic       ci;         // Cache inhibit.
    logic [3:0] rsvd0;
    logic       handshake_return_flag;      // handshake_return_flag
    logic [2:0] transfer_latency_field;      // transfer_latency_field
    logic [1:0] ps;         // port_width_field
    logic [1:0] pin_function_field;       // pin_function_field
    logic [1:0] byte_sel;
    logic [2:0] region;
    logic [1:0] rsvd1;
    logic [3:0] interface_kind_field;      // interface_kind_field
  } rdnp_opt_s;

  localparam logic [3:0] EXTENT_OFF = 4'h0;
  localparam logic [1:0] PIN_FUNCTION_FIELD_UNIT_ENABLE = 2'h0;

  // Reserved bits are held at zero and read as zero.
  localparam rdnp_opt_s OPT_WMASK = '{rsvd0: '0, rsvd1: '0, default: '1};
  localparam rdnp_opt_s OPT_RESET = '{default: '0};
  // Boot region comes up live so the first fetches find their device.
  localparam rdnp_opt_s BOOT_OPT_RESET =
    '{extent: 4'hf, handshake_return_flag: 1'b1, ps: 2'h2, default: '0};

  // Boot origin picked by the exception prefix bit at reset.
  localparam logic [ORIGIN_W-1:0] BOOT_ORIGIN_PREFIX_0 = 20'h00000;
  localparam logic [ORIGIN_W-1:0] BOOT_ORIGIN_PREFIX_1 = 20'hfff00;
  localparam logic [ORIGIN_W-1:0] ORIGIN_RESET         = 20'h00000;

  // ==========================================================================
  // Access request and answer carriers
  // ==========================================================================
  typedef struct packed {
    logic              valid;     // One-cycle access strobe.
    logic [ADDR_W-1:0] addr;
    logic              priv;      // privilege_level_signal: 1 privileged.
    logic              fetch;     // fetch_or_load_signal: 1 instruction.
    logic              write_n;   // Low for a store.
    logic              internal;  // An on-chip module claims the address.
  } rdnp_acc_s;

  typedef struct packed {
    logic       ci;
    logic       handshake_return_flag;
    logic [2:0] transfer_latency_field;
    logic [1:0] ps;
    logic [3:0] interface_kind_field;
  } rdnp_attr_s;

  typedef struct packed {
    logic       hit;
    logic       error;
    logic       nested;
    logic [2:0] line;
  } rdnp_stat_s;

endpackage : rdnp_pkg

// file: rdnp_region_match.sv
// Origin and extent comparator for one decoder.
`timescale 1ns/1ps
`default_nettype none
module rdnp_region_match
  import rdnp_pkg::*;
(
  input  wire logic [ORIGIN_W-1:0] origin_i,
  input  wire logic [3:0]          extent_i,
  input  wire logic [ORIGIN_W-1:0] addr_hi_i,
  output logic                     hit_o
);

  // ==========================================================================
  // Compare
  // ==========================================================================
  logic [DROP_W-1:0]   drop;
  logic [ORIGIN_W-1:0] mask;

  // Each extent step past the smallest drops one low line from the compare.
  always_comb
  begin
    drop  = {1'b0, extent_i} - 5'h01;
    mask  = {ORIGIN_W{1'b1}} << drop;
    hit_o = (extent_i != EXTENT_OFF) &&
            (((addr_hi_i ^ origin_i) & mask) == '0);
  end

endmodule : rdnp_region_match
`default_nettype wire

// file: rdnp_prot_check.sv
// Access protection check against one set of option settings.
`timescale 1ns/1ps
`default_nettype none
module rdnp_prot_check
  import rdnp_pkg::*;
(
  input  wire rdnp_opt_s opt_i,
  input  wire rdnp_acc_s acc_i,
  output logic           violation_o
);

  // ==========================================================================
  // Violation terms
  // ==========================================================================
  // Privilege is checked on data accesses only; fetches are exempt.
  always_comb
  begin
    violation_o = (opt_i.privileged_only_flag && !acc_i.priv && !acc_i.fetch) ||
                  (opt_i.dsp && acc_i.fetch) ||
                  (opt_i.wp && !acc_i.write_n);
  end

endmodule : rdnp_prot_check
`default_nettype wire

// file: rdnp_decoder_props.sv
// Port-level assertions for the region decoder.
`timescale 1ns/1ps
`default_nettype none
module rdnp_decoder_props
  import rdnp_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  rst_n_i,
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [ADDR_W-1:0]     reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [ADDR_W-1:0]     reg_rdata_o,
  input wire logic                  exception_prefix_bit_i,
  input wire rdnp_acc_s             acc_i,
  input wire logic [NUM_LINES-1:0]  region_select_n_o,
  input wire logic                  transfer_error_signal_o,
  input wire rdnp_attr_s            attr_o
);
  logic fresh_reg;
  logic pfx_reg;

  // ==========================================================================
  // Helper state
  // ==========================================================================
  // Reset values only hold until software writes, so track that.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      fresh_reg <= 1'b1;
      pfx_reg   <= exception_prefix_bit_i;
    end
    else if (reg_wr_i)
      fresh_reg <= 1'b0;
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_one_enable: assert property (
    $onehot0(~region_select_n_o)) else $error("two enables at once");
  a_err_no_sel: assert property (
    transfer_error_signal_o |-> &region_select_n_o)
    else $error("enable asserted with error");
  a_idle_quiet: assert property (
    !acc_i.valid |=> &region_select_n_o && !transfer_error_signal_o
    && attr_o == '0) else $error("output without access");
  a_internal_wins: assert property (
    acc_i.valid && acc_i.internal |=> &region_select_n_o
    && !transfer_error_signal_o) else $error("external cycle on internal");
  a_err_cause: assert property (
    transfer_error_signal_o |-> $past(acc_i.valid)
    && !$past(acc_i.internal)) else $error("error without cause");
  a_sel_cause: assert property (
    !(&region_select_n_o) |-> $past(acc_i.valid))
    else $error("enable without access");
  a_boot_origin: assert property (
    fresh_reg && reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o ==
    {(pfx_reg ? BOOT_ORIGIN_PREFIX_1 : BOOT_ORIGIN_PREFIX_0), 12'h000})
    else $error("boot origin reset value wrong");
  a_nest_flag_clr: assert property (
    fresh_reg && reg_rd_i && reg_addr_i == 8'h38 |=> reg_rdata_o == '0)
    else $error("boot nested option not clear");
endmodule : rdnp_decoder_props

bind rdnp_decoder rdnp_decoder_props rdnp_decoder_props_i (
  .ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .exception_prefix_bit_i, .acc_i, .region_select_n_o,
  .transfer_error_signal_o, .attr_o);
`default_nettype wire

// file: rdnp_chip_model.sv
// External chips behind the region enables; each counts its own cycles.
`timescale 1ns/1ps
`default_nettype none
module rdnp_chip_model
  import rdnp_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [NUM_LINES-1:0] region_select_n_i,
  output int                        hits_o [NUM_LINES]
);
  // A chip answers only to its own enable, shared by the whole region.
  always_ff @(posedge ref_clk_i)
  begin
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (!rst_n_i)
        hits_o[i] <= 0;
      else
        hits_o[i] <= hits_o[i] + int'(!region_select_n_i[i]);
    end
  end
endmodule : rdnp_chip_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the region decoder with nested protection.
`timescale 1ns/1ps
`default_nettype none
module tb
  import rdnp_pkg::*;
;
  logic                  ref_clk_i;
  logic                  rst_n_i;
  logic                  reg_wr_i;
  logic                  reg_rd_i;
  logic                  exception_prefix_bit_i;
  logic [REG_ADDR_W-1:0] reg_addr_i;
  logic [ADDR_W-1:0]     reg_wdata_i;
  logic [ADDR_W-1:0]     reg_rdata_o;
  rdnp_acc_s             acc_i;
  logic [NUM_LINES-1:0]  region_select_n_o;
  logic                  transfer_error_signal_o;
  rdnp_attr_s            attr_o;
  int                    hits [NUM_LINES];
  int                    ecnt [NUM_LINES];
  int                    err_count;
  int                    comparisons;
  logic [19:0]           org [NUM_DEC];
  rdnp_opt_s             opt [NUM_DEC];
  logic [NUM_LINES-1:0]  e_sel;
  logic                  e_err;
  rdnp_attr_s            e_attr;
  logic [5:0]            e_stat;
  logic [31:0]           d;

  rdnp_decoder rdnp_decoder_i (.ref_clk_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .exception_prefix_bit_i, .acc_i, .region_select_n_o,
    .transfer_error_signal_o, .attr_o);
  rdnp_chip_model rdnp_chip_model_i (.ref_clk_i, .rst_n_i,
    .region_select_n_i(region_select_n_o), .hits_o(hits));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic finish_test;
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // Reset also restores the reference copy of the register file.
  task automatic do_reset(logic pf);
    @(posedge ref_clk_i);
    rst_n_i                <= 1'b0;
    exception_prefix_bit_i <= pf;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (org[i])
    begin
      org[i] = '0;
      opt[i] = OPT_RESET;
    end
    org[0] = pf ? BOOT_ORIGIN_PREFIX_1 : BOOT_ORIGIN_PREFIX_0;
    opt[0] = BOOT_OPT_RESET;
    foreach (ecnt[i]) ecnt[i] = 0;
    e_stat = '0;
  endtask : do_reset

  // ==========================================================================
  // Reference model
  // ==========================================================================
  // Shifting both sides drops the lines that the extent leaves out.
  function automatic bit hit(int k, logic [31:0] a);
    int s;
    s = 11 + int'(opt[k].extent);
    return opt[k].extent != 0 && (a >> s) == ({org[k], 12'h000} >> s);
  endfunction : hit

  task automatic model(rdnp_acc_s a);
    int        l;
    int        n;
    rdnp_opt_s p;
    l = -1;
    n = -1;
    e_sel = '1;
    e_err = 1'b0;
    e_attr = '0;
    // Any strobe that reaches no external line leaves a clear status.
    if (a.valid) e_stat = '0;
    if (!a.valid || a.internal) return;
    for (int i = NUM_LINES - 1; i >= 0; i--)
      if (hit(i, a.addr) && opt[i].pin_function_field == 0 && !(i % 2 && opt[i].nested))
        l = i;
    if (l < 0) return;
    if (l % 2 == 0 && opt[l + 1].nested && hit(l + 1, a.addr)) n = l + 1;
    else if (l == 0 && opt[6].nested && hit(6, a.addr)) n = 6;
    p = opt[l];
    if (n >= 0)
    begin
      p = opt[n];
      p.handshake_return_flag |= opt[l].handshake_return_flag;
      p.transfer_latency_field |= opt[l].transfer_latency_field;
      p.ps |= opt[l].ps;
      p.interface_kind_field |= opt[l].interface_kind_field;
    end
    e_err = p.privileged_only_flag && !a.priv && !a.fetch || p.dsp && a.fetch
            || p.wp && !a.write_n;
    e_stat = {1'b1, e_err, n >= 0, 3'(l)};
    e_attr = {p.ci, p.handshake_return_flag, p.transfer_latency_field, p.ps, p.interface_kind_field};
    if (!e_err) e_sel[l] = 1'b0;
  endtask : model

  task automatic compare;
    chk("select", 32'(e_sel), 32'(region_select_n_o));
    chk("error", 32'(e_err), 32'(transfer_error_signal_o));
    if (!e_err) chk("attr", 32'(e_attr), 32'(attr_o));
    foreach (ecnt[i]) ecnt[i] += int'(!e_sel[i]);
  endtask : compare

  // Back-to-back random accesses, mostly aimed inside a programmed block.
  task automatic burst(int k);
    rdnp_acc_s a;
    int        x;
    bit        p;
    p = 0;
    repeat (k)
    begin
      x = $urandom % NUM_DEC;
      a.addr = {org[x], 12'h000}
               | ($urandom & ((32'h1 << (11 + opt[x].extent)) - 1));
      if ($urandom % 8 == 0) a.addr = $urandom;
      a.valid = $urandom % 4 != 0;
      a.priv = 1'($urandom);
      a.fetch = 1'($urandom);
      a.write_n = 1'($urandom);
      a.internal = $urandom % 8 == 0;
      @(posedge ref_clk_i);
      acc_i <= a;
      #1 if (p) compare;
      model(a);
      p = 1;
    end
    @(posedge ref_clk_i);
    acc_i.valid <= 1'b0;
    #1 compare;
  endtask : burst

  // Random map; origins aligned to the block, a shared top nibble
  // makes main and nested blocks overlap often.
  task automatic configure;
    rdnp_opt_s   o;
    logic [19:0] g;
    int          m;
    for (int k = 0; k < NUM_DEC; k++)
    begin
      o = rdnp_opt_s'($urandom) & OPT_WMASK;
      if ($urandom % 4 != 0) o.pin_function_field = PIN_FUNCTION_FIELD_UNIT_ENABLE;
      // Half the nested decoders follow the software rules, the rest
      // break them so that the merge of mismatched settings is seen too.
      m = (k == DEC_BOOT_NEST) ? LINE_BOOT : k - 1;
      if ((k % 2 == 1 || k == DEC_BOOT_NEST) && $urandom % 2 == 0)
      begin
        o.interface_kind_field = opt[m].interface_kind_field;
        o.handshake_return_flag = opt[m].handshake_return_flag;
        o.transfer_latency_field = opt[m].transfer_latency_field;
        o.ps    = opt[m].ps;
        if (opt[m].extent > 4'h1)
          o.extent = 4'(1 + $urandom % (opt[m].extent - 1));
      end
      g = {4'ha, 16'($urandom)};
      if (o.extent != 0) g &= ~((20'h1 << (o.extent - 1)) - 1);
      wr(8'(4 * k), {g, 12'h000});
      wr(8'(8'h20 + 4 * k), o);
      org[k] = g;
      opt[k] = o;
    end
  endtask : configure

  // ==========================================================================
  // Clock, stimulus and watchdog
  // ==========================================================================
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    err_count++;
    finish_test();
  end

  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, exception_prefix_bit_i} = '0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    acc_i = '0;
    err_count = 0;
    comparisons = 0;
    void'($urandom(20170));
    do_reset(1'b1);
    rd(8'h00);
    chk("boot origin", {org[0], 12'h000}, d);
    rd(8'h20);
    chk("boot option", BOOT_OPT_RESET, d);
    rd(8'h38);
    chk("boot nested option", 32'h0, d);
    rd(8'h1c);
    chk("unmapped", 32'h0, d);
    burst(20);
    wr(8'h38, '1);
    rd(8'h38);
    chk("option mask", OPT_WMASK, d);
    repeat (40)
    begin
      configure();
      burst(40);
      rd(8'h40);
      chk("status", 32'(e_stat), d);
    end
    // Let the chips count the enable of the last access first.
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    foreach (ecnt[i]) chk("chip hits", ecnt[i], hits[i]);
    do_reset(1'b0);
    rd(8'h00);
    chk("boot origin", 32'h0, d);
    finish_test();
  end
endmodule : tb
`default_nettype wire
